// file: core/ccs_pkg.sv
// package: register layouts, reset values and timing constants of the cpu clock switch guard
package ccs_pkg;
   // clock mode select register bits
   localparam int MAIN_EXT_SELECT_BIT = 7;
   localparam int MAIN_SRC_ENABLE_BIT = 6;
   localparam int SUB_EXT_SELECT_BIT  = 5;
   localparam int SUB_SRC_ENABLE_BIT  = 4;
   localparam int HF_AMP_MODE_BIT     = 0;
   // main oscillator control register bits
   localparam int MAIN_OSC_STOP_BIT   = 7;
   // main clock mode register bits
   localparam int HS_SRC_LATCH_BIT    = 2;
   localparam int MAIN_CLK_STATUS_BIT = 1;
   localparam int MAIN_CLK_SELECT_BIT = 0;
   // processor clock control register bits
   localparam int SUB_AMP_START_BIT   = 6;
   localparam int CPU_SUB_SELECT_BIT  = 4;
   // ring oscillator mode register bits
   localparam int RING_OSC_STATUS_BIT = 7;
   localparam int RING_OSC_STOP_BIT   = 0;
   // reset values
   localparam logic [7:0] CMS_RESET = 8'h00;
   localparam logic [7:0] MOC_RESET = 8'h80;
   localparam logic [7:0] MCM_RESET = 8'h00;
   localparam logic [7:0] PCC_RESET = 8'h00;
   localparam logic [7:0] RCM_RESET = 8'h00;
   // timing
   localparam int CLK_FREQ_MHZ      = 25;
   localparam int HF_GATE_TIME_US   = 5;
   localparam int HF_GATE_CYCLES    = HF_GATE_TIME_US * CLK_FREQ_MHZ;
   localparam int SWITCH_SYNC_DEPTH = 2;

   // one cpu clock source selection
   typedef enum logic [1:0] {CCS_SRC_RING, CCS_SRC_MAIN, CCS_SRC_SUB} ccs_src_t;

   // software write to one register
   typedef struct packed {
      logic       cms_we;
      logic       moc_we;
      logic       mcm_we;
      logic       pcc_we;
      logic       rcm_we;
      logic [7:0] wdata;
   } ccs_wr_t;

   // register images seen by software
   typedef struct packed {
      logic [7:0] cms;
      logic [7:0] main_osc_control_reg;
      logic [7:0] main_clock_mode_reg;
      logic [7:0] processor_clock_control_reg;
      logic [7:0] ring_osc_mode_reg;
   } ccs_regs_t;
endpackage : ccs_pkg

// file: core/ccs_switch_sync.sv
// module: handshake that moves the clock mux select only after the old source is quiet
`timescale 1ns/100ps
module ccs_switch_sync
#(
   parameter int DEPTH = ccs_pkg::SWITCH_SYNC_DEPTH
)
(
   // clock and reset
   input  wire logic             i_clock,
   input  wire logic             i_sys_rst,
   // request and result
   input  wire ccs_pkg::ccs_src_t i_req_src,
   input  wire logic             i_gate,
   output      ccs_pkg::ccs_src_t o_cur_src,
   output      logic             o_busy
);
   typedef enum {ST_IDLE, ST_OFF, ST_MOVE} ccs_sw_st_t;
   ccs_sw_st_t        st_r, st_nxt;
   logic [7:0]        cnt_r, cnt_nxt;
   ccs_pkg::ccs_src_t src_r, src_nxt;
   logic              busy_r, busy_nxt;

   ////////////////////////////////////////////////////////////////////////
   // break-before-make: enable drops, wait, then mux moves, wait, enable back
   always_comb
   begin
      st_nxt   = st_r;
      cnt_nxt  = cnt_r;
      src_nxt  = src_r;
      busy_nxt = 1'b1;
      case (st_r)
         ST_IDLE:
         begin
            busy_nxt = 1'b0;
            if (i_req_src != src_r)
            begin
               st_nxt   = ST_OFF; // (R20)
               cnt_nxt  = 8'(DEPTH);
               busy_nxt = 1'b1;
            end
         end
         ST_OFF:
         begin
            if (cnt_r != 8'h00)
               cnt_nxt = cnt_r - 8'h01;
            else
            begin
               src_nxt = i_req_src; // (R20)
               cnt_nxt = 8'(DEPTH);
               st_nxt  = ST_MOVE;
            end
         end
         ST_MOVE:
         begin
            if (cnt_r != 8'h00)
               cnt_nxt = cnt_r - 8'h01;
            else
               st_nxt = ST_IDLE;
         end
         default:
            st_nxt = ST_IDLE;
      endcase
      if (i_gate)
         busy_nxt = 1'b1;
   end

   // state registers
   always_ff @(posedge i_clock or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         st_r   <= ST_IDLE;
         cnt_r  <= 8'h00;
         src_r  <= ccs_pkg::CCS_SRC_RING;
         busy_r <= 1'b0;
      end
      else
      begin
         st_r   <= st_nxt;
         cnt_r  <= cnt_nxt;
         src_r  <= src_nxt;
         busy_r <= busy_nxt;
      end
   end

   assign o_cur_src = src_r;
   assign o_busy    = busy_r;
endmodule : ccs_switch_sync

// file: core/ccs_guard.sv
// module: cpu clock source guard, hf amp clock hold and source stop control
// Behaviour
// (R1) software readies main crystal, waits stabilization
// (R2) software readies external main clock input
// (R3) ring oscillator may stop on main clock
// (R4) cpu clock held 5 us after hf_amp_mode
// (R5) back to ring needs ring running first; the mux switch does not check the ring stop bit
// (R6) software readies sub crystal, waits stabilization
// (R7) software readies external sub clock input
// (R8) ring oscillator may stop on sub clock
// (R9) return to ring needs ring selected main
// (R10) sub source may stop after leaving it
// (R11) sub to crystal needs main status 1
// (R12) sub to external main needs status 1
// (R13) mode select bits 7, 6, 0
// (R14) main oscillator stop at bit 7
// (R15) latch bit 2, main select bit 0
// (R16) cpu sub select at bit 4
// (R17) sub start bit 6, sub bits 5, 4
// (R18) ring stop bit 0, status bit 7
// (R19) main clock status at bit 1
// (R20) clock mux moves only glitch free
`timescale 1ns/100ps
module ccs_guard
#(
   parameter int HF_GATE_CYCLES = ccs_pkg::HF_GATE_CYCLES
)
(
   // clock and reset
   input  wire logic              i_clock,
   input  wire logic              i_sys_rst,
   // software register writes
   input  wire ccs_pkg::ccs_wr_t  i_wr,
   // register images
   output      ccs_pkg::ccs_regs_t o_regs,
   // source enables toward the oscillators
   output      logic              o_ring_osc_en,
   output      logic              o_main_osc_en,
   output      logic              o_main_ext_en,
   output      logic              o_sub_osc_en,
   output      logic              o_sub_ext_en,
   output      logic              o_hf_amp,
   // cpu clock mux
   output      ccs_pkg::ccs_src_t o_cpu_src,
   output      logic              o_cpu_clk_en
);
   logic [7:0] cms_r, cms_nxt;
   logic [7:0] moc_r, moc_nxt;
   logic [7:0] mcm_r, mcm_nxt;
   logic [7:0] pcc_r, pcc_nxt;
   logic [7:0] rcm_r, rcm_nxt;
   logic       latch_done_r, latch_done_nxt;
   logic       amp_done_r, amp_done_nxt;
   logic [15:0] gate_cnt_r, gate_cnt_nxt;
   logic       gate_r, gate_nxt;
   ccs_pkg::ccs_regs_t regs_r, regs_nxt;
   logic       ring_en_r, ring_en_nxt;
   logic       mosc_en_r, mosc_en_nxt;
   logic       mext_en_r, mext_en_nxt;
   logic       sosc_en_r, sosc_en_nxt;
   logic       sext_en_r, sext_en_nxt;
   logic       amp_r, amp_nxt;
   logic       clk_en_r, clk_en_nxt;
   ccs_pkg::ccs_src_t src_q_r, src_q_nxt;
   ccs_pkg::ccs_src_t req_src;
   ccs_pkg::ccs_src_t cur_src;
   logic       sw_busy;
   logic       on_ring, on_main, on_sub;
   logic       ring_stop_ok, main_stop_ok, sub_stop_ok;

   localparam logic [15:0] GATE_LOAD = 16'(HF_GATE_CYCLES);

   ////////////////////////////////////////////////////////////////////////
   // where the cpu clock really is, from the glitch-free mux
   assign on_sub  = (cur_src == ccs_pkg::CCS_SRC_SUB);
   assign on_main = (cur_src == ccs_pkg::CCS_SRC_MAIN);
   assign on_ring = (cur_src == ccs_pkg::CCS_SRC_RING);
   // ring stop, main stop and sub disable writes take effect only when the cpu runs on something else and no switch is busy
   assign ring_stop_ok = !on_ring && !sw_busy;           // (R3) (R8)
   assign main_stop_ok = !on_main && !sw_busy;           // (R5)
   assign sub_stop_ok  = !on_sub && !sw_busy;            // (R10)

   // requested source from cpu_sub_select and main_clk_select
   always_comb
   begin
      if (pcc_r[ccs_pkg::CPU_SUB_SELECT_BIT])
         req_src = ccs_pkg::CCS_SRC_SUB;                  // (R16)
      else if (mcm_r[ccs_pkg::MAIN_CLK_SELECT_BIT])
         req_src = ccs_pkg::CCS_SRC_MAIN;                 // (R15)
      else
         req_src = ccs_pkg::CCS_SRC_RING;
   end

   ////////////////////////////////////////////////////////////////////////
   // register file next values
   always_comb
   begin
      cms_nxt        = cms_r;
      moc_nxt        = moc_r;
      mcm_nxt        = mcm_r;
      pcc_nxt        = pcc_r;
      rcm_nxt        = rcm_r;
      latch_done_nxt = latch_done_r;
      amp_done_nxt   = amp_done_r;
      if (i_wr.cms_we)
      begin
         cms_nxt[ccs_pkg::MAIN_EXT_SELECT_BIT] = i_wr.wdata[ccs_pkg::MAIN_EXT_SELECT_BIT]; // (R13)
         cms_nxt[ccs_pkg::MAIN_SRC_ENABLE_BIT] = i_wr.wdata[ccs_pkg::MAIN_SRC_ENABLE_BIT]; // (R13)
         cms_nxt[ccs_pkg::SUB_EXT_SELECT_BIT]  = i_wr.wdata[ccs_pkg::SUB_EXT_SELECT_BIT];  // (R17)
         // sub source can be disabled only once the cpu has left it
         if (i_wr.wdata[ccs_pkg::SUB_SRC_ENABLE_BIT] || sub_stop_ok)
            cms_nxt[ccs_pkg::SUB_SRC_ENABLE_BIT] = i_wr.wdata[ccs_pkg::SUB_SRC_ENABLE_BIT]; // (R10) (R17)
         // amp mode takes one write after reset
         if (!amp_done_r)
         begin
            cms_nxt[ccs_pkg::HF_AMP_MODE_BIT] = i_wr.wdata[ccs_pkg::HF_AMP_MODE_BIT]; // (R13)
            amp_done_nxt = 1'b1;
         end
      end
      if (i_wr.moc_we)
      begin
         if (!i_wr.wdata[ccs_pkg::MAIN_OSC_STOP_BIT] || main_stop_ok)
            moc_nxt[ccs_pkg::MAIN_OSC_STOP_BIT] = i_wr.wdata[ccs_pkg::MAIN_OSC_STOP_BIT]; // (R5) (R14)
      end
      if (i_wr.mcm_we)
      begin
         // source latch may change once after reset
         if (!latch_done_r)
         begin
            mcm_nxt[ccs_pkg::HS_SRC_LATCH_BIT] = i_wr.wdata[ccs_pkg::HS_SRC_LATCH_BIT]; // (R15)
            latch_done_nxt = 1'b1;
         end
         mcm_nxt[ccs_pkg::MAIN_CLK_SELECT_BIT] = i_wr.wdata[ccs_pkg::MAIN_CLK_SELECT_BIT]; // (R15)
      end
      if (i_wr.pcc_we)
      begin
         pcc_nxt[ccs_pkg::SUB_AMP_START_BIT]  = i_wr.wdata[ccs_pkg::SUB_AMP_START_BIT];  // (R17)
         pcc_nxt[ccs_pkg::CPU_SUB_SELECT_BIT] = i_wr.wdata[ccs_pkg::CPU_SUB_SELECT_BIT]; // (R16)
      end
      if (i_wr.rcm_we)
      begin
         // stopping the ring oscillator under the cpu is refused
         if (!i_wr.wdata[ccs_pkg::RING_OSC_STOP_BIT] || ring_stop_ok)
            rcm_nxt[ccs_pkg::RING_OSC_STOP_BIT] = i_wr.wdata[ccs_pkg::RING_OSC_STOP_BIT]; // (R3) (R5) (R8) (R18)
      end
      // status bits follow hardware
      // on the sub clock the main system clock is off the cpu mux, so status follows the select bit
      mcm_nxt[ccs_pkg::MAIN_CLK_STATUS_BIT] = on_sub ? mcm_nxt[ccs_pkg::MAIN_CLK_SELECT_BIT]
                                            : (on_main || (src_q_r == ccs_pkg::CCS_SRC_MAIN)); // (R19)
      rcm_nxt[ccs_pkg::RING_OSC_STATUS_BIT] = rcm_nxt[ccs_pkg::RING_OSC_STOP_BIT]; // (R18)
   end

   // register file
   always_ff @(posedge i_clock or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         cms_r        <= ccs_pkg::CMS_RESET;
         moc_r        <= ccs_pkg::MOC_RESET;
         mcm_r        <= ccs_pkg::MCM_RESET;
         pcc_r        <= ccs_pkg::PCC_RESET;
         rcm_r        <= ccs_pkg::RCM_RESET;
         latch_done_r <= 1'b0;
         amp_done_r   <= 1'b0;
      end
      else
      begin
         cms_r        <= cms_nxt;
         moc_r        <= moc_nxt;
         mcm_r        <= mcm_nxt;
         pcc_r        <= pcc_nxt;
         rcm_r        <= rcm_nxt;
         latch_done_r <= latch_done_nxt;
         amp_done_r   <= amp_done_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // hf amp clock hold: counts whole cycles, the 5 us is exactly 125 at 25 MHz with no rounding
   always_comb
   begin
      gate_cnt_nxt = gate_cnt_r;
      gate_nxt     = gate_r;
      if (cms_nxt[ccs_pkg::HF_AMP_MODE_BIT] && !cms_r[ccs_pkg::HF_AMP_MODE_BIT])
      begin
         gate_nxt     = 1'b1;                             // (R4)
         gate_cnt_nxt = GATE_LOAD;
      end
      else if (gate_r)
      begin
         if (gate_cnt_r > 16'h0001)
            gate_cnt_nxt = gate_cnt_r - 16'h0001;         // (R4)
         else
         begin
            gate_cnt_nxt = 16'h0000;
            gate_nxt     = 1'b0;
         end
      end
   end

   // hold counter
   always_ff @(posedge i_clock or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         gate_cnt_r <= 16'h0000;
         gate_r     <= 1'b0;
      end
      else
      begin
         gate_cnt_r <= gate_cnt_nxt;
         gate_r     <= gate_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // mux select moves break-before-make
   ccs_switch_sync u_switch
   (
      .i_clock   (i_clock),
      .i_sys_rst (i_sys_rst),
      .i_req_src (req_src),
      .i_gate    (gate_r),
      .o_cur_src (cur_src),
      .o_busy    (sw_busy)
   );

   // output images and oscillator enables
   always_comb
   begin
      regs_nxt     = '{cms: cms_r, main_osc_control_reg: moc_r, main_clock_mode_reg: mcm_r, processor_clock_control_reg: pcc_r, ring_osc_mode_reg: rcm_r};
      ring_en_nxt  = !rcm_r[ccs_pkg::RING_OSC_STOP_BIT];
      mosc_en_nxt  = !moc_r[ccs_pkg::MAIN_OSC_STOP_BIT] && cms_r[ccs_pkg::MAIN_SRC_ENABLE_BIT]
                     && !cms_r[ccs_pkg::MAIN_EXT_SELECT_BIT];
      mext_en_nxt  = !moc_r[ccs_pkg::MAIN_OSC_STOP_BIT] && cms_r[ccs_pkg::MAIN_SRC_ENABLE_BIT]
                     && cms_r[ccs_pkg::MAIN_EXT_SELECT_BIT];
      // the sub start bit, or the sub enable bit with ext select clear, runs the sub amplifier
      sosc_en_nxt  = pcc_r[ccs_pkg::SUB_AMP_START_BIT] || (cms_r[ccs_pkg::SUB_SRC_ENABLE_BIT]
                     && !cms_r[ccs_pkg::SUB_EXT_SELECT_BIT]);
      sext_en_nxt  = !pcc_r[ccs_pkg::SUB_AMP_START_BIT] && cms_r[ccs_pkg::SUB_SRC_ENABLE_BIT]
                     && cms_r[ccs_pkg::SUB_EXT_SELECT_BIT];
      amp_nxt      = cms_r[ccs_pkg::HF_AMP_MODE_BIT];
      clk_en_nxt   = !sw_busy && !gate_r;                 // (R4) (R20)
      src_q_nxt    = cur_src;
   end

   // output flops
   always_ff @(posedge i_clock or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         regs_r    <= '0;
         ring_en_r <= 1'b1;
         mosc_en_r <= 1'b0;
         mext_en_r <= 1'b0;
         sosc_en_r <= 1'b0;
         sext_en_r <= 1'b0;
         amp_r     <= 1'b0;
         clk_en_r  <= 1'b0;
         src_q_r   <= ccs_pkg::CCS_SRC_RING;
      end
      else
      begin
         regs_r    <= regs_nxt;
         ring_en_r <= ring_en_nxt;
         mosc_en_r <= mosc_en_nxt;
         mext_en_r <= mext_en_nxt;
         sosc_en_r <= sosc_en_nxt;
         sext_en_r <= sext_en_nxt;
         amp_r     <= amp_nxt;
         clk_en_r  <= clk_en_nxt;
         src_q_r   <= src_q_nxt;
      end
   end

   assign o_regs        = regs_r;
   assign o_ring_osc_en = ring_en_r;
   assign o_main_osc_en = mosc_en_r;
   assign o_main_ext_en = mext_en_r;
   assign o_sub_osc_en  = sosc_en_r;
   assign o_sub_ext_en  = sext_en_r;
   assign o_hf_amp      = amp_r;
   assign o_cpu_src     = src_q_r;
   assign o_cpu_clk_en  = clk_en_r;
endmodule : ccs_guard

// file: testbench/ccs_osc_model.sv
// model: oscillators and clock pins beyond the guard
`timescale 1ns/100ps
module ccs_osc_model
#(
   parameter int STAB_CYCLES = 16
)
(
   // clock and reset
   input  wire logic i_clock,
   input  wire logic i_sys_rst,
   // enables from the guard
   input  wire logic i_main_osc_en,
   input  wire logic i_main_ext_en,
   input  wire logic i_sub_osc_en,
   input  wire logic i_sub_ext_en,
   // readiness seen by software
   output      logic o_main_ready,
   output      logic o_sub_ready
);
   int main_cnt;
   int sub_cnt;
   // crystals settle slowly, so any drop of the enable restarts the count
   always @(posedge i_clock or posedge i_sys_rst)
   begin
      main_cnt <= (i_sys_rst || !i_main_osc_en) ? 0 : main_cnt + 1;
      sub_cnt  <= (i_sys_rst || !i_sub_osc_en) ? 0 : sub_cnt + 1;
   end
   // external inputs need no settling
   assign o_main_ready = i_main_ext_en || (main_cnt >= STAB_CYCLES);
   assign o_sub_ready  = i_sub_ext_en || (sub_cnt >= STAB_CYCLES);
endmodule : ccs_osc_model

// file: testbench/ccs_guard_properties.sv
// checker: timing and decode properties of the clock switch guard
`timescale 1ns/100ps
module ccs_guard_props
#(
   parameter int HF_GATE_CYCLES = 125
)
(
   // clock and reset
   input wire logic               i_clock,
   input wire logic               i_sys_rst,
   // register side
   input wire ccs_pkg::ccs_wr_t   i_wr,
   input wire ccs_pkg::ccs_regs_t o_regs,
   // source side
   input wire logic               o_ring_osc_en,
   input wire logic               o_main_osc_en,
   input wire logic               o_main_ext_en,
   input wire logic               o_sub_osc_en,
   input wire logic               o_sub_ext_en,
   input wire logic               o_hf_amp,
   input wire ccs_pkg::ccs_src_t  o_cpu_src,
   input wire logic               o_cpu_clk_en
);
   logic [15:0] lo_cnt_r, lo_cnt_nxt;
   logic        pend_r, pend_nxt, hf_q_r;
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (i_sys_rst);
   ////////////////////////////////////////////////////////////////////////////
   // low-time counter; a hold armed by hf mode must last the whole gate
   always_comb
   begin
      lo_cnt_nxt = o_cpu_clk_en ? 16'h0 : lo_cnt_r + 16'h1;
      pend_nxt   = (o_hf_amp & ~hf_q_r) | (pend_r & ~(o_cpu_clk_en & (lo_cnt_r != 16'h0)));
   end
   // register the helpers
   always_ff @(posedge i_clock or posedge i_sys_rst)
   begin
      if (i_sys_rst)
         {lo_cnt_r, pend_r, hf_q_r} <= '0;
      else
         {lo_cnt_r, pend_r, hf_q_r} <= {lo_cnt_nxt, pend_nxt, o_hf_amp};
   end
   ////////////////////////////////////////////////////////////////////////////
   a_mux_move_gated: assert property ($changed(o_cpu_src) |-> !o_cpu_clk_en && !$past(o_cpu_clk_en))
      else $error("cpu source moved while clock supplied");
   a_gate_bounded: assert property ($fell(o_cpu_clk_en) |-> ##[1:400] o_cpu_clk_en)
      else $error("cpu clock held too long");
   a_hf_hold_len: assert property (o_cpu_clk_en && lo_cnt_r != 16'h0 && pend_r |-> lo_cnt_r >= HF_GATE_CYCLES)
      else $error("hf hold too short");
   a_ring_kept: assert property (o_cpu_src == ccs_pkg::CCS_SRC_RING |-> o_ring_osc_en)
      else $error("ring stopped while in use");
   a_main_kept: assert property (o_cpu_src == ccs_pkg::CCS_SRC_MAIN |-> o_main_osc_en || o_main_ext_en)
      else $error("main source stopped while in use");
   a_sub_kept: assert property (o_cpu_src == ccs_pkg::CCS_SRC_SUB |-> o_sub_osc_en || o_sub_ext_en)
      else $error("sub source stopped while in use");
   a_main_decode: assert property (o_main_osc_en == (!o_regs.main_osc_control_reg[7] && o_regs.cms[6] && !o_regs.cms[7])
      && o_main_ext_en == (!o_regs.main_osc_control_reg[7] && o_regs.cms[6] && o_regs.cms[7]))
      else $error("main enable decode wrong");
   a_sub_decode: assert property (o_sub_osc_en == (o_regs.processor_clock_control_reg[6] || (o_regs.cms[4] && !o_regs.cms[5]))
      && o_sub_ext_en == (!o_regs.processor_clock_control_reg[6] && o_regs.cms[4] && o_regs.cms[5]))
      else $error("sub enable decode wrong");
   a_status_main: assert property (o_cpu_src == ccs_pkg::CCS_SRC_MAIN [*3] |-> o_regs.main_clock_mode_reg[1])
      else $error("status low on main");
   a_status_ring: assert property (o_cpu_src == ccs_pkg::CCS_SRC_RING [*3] |-> !o_regs.main_clock_mode_reg[1])
      else $error("status high on ring");
   a_unused_zero: assert property (((o_regs.cms & 8'h0e) | (o_regs.main_osc_control_reg & 8'h7f) | (o_regs.main_clock_mode_reg & 8'hf8)
      | (o_regs.processor_clock_control_reg & 8'haf) | (o_regs.ring_osc_mode_reg & 8'h7e)) == 8'h00)
      else $error("unused register bit set");
   c_on_main: cover property (o_cpu_src == ccs_pkg::CCS_SRC_MAIN);
   c_on_sub: cover property (o_cpu_src == ccs_pkg::CCS_SRC_SUB);
   c_hf_hold: cover property (pend_r && !o_cpu_clk_en);
endmodule : ccs_guard_props

// file: testbench/cpu_clock_switch_guard_test.sv
// testbench: walks the guard through its source changes
`timescale 1ns/100ps
module cpu_clock_switch_guard_test;
   localparam int HF_CYC = 8;
   localparam int CMS = 0, MAIN_OSC_CONTROL_REG = 1, MAIN_CLOCK_MODE_REG = 2, PROCESSOR_CLOCK_CONTROL_REG = 3, RING_OSC_MODE_REG = 4;
   logic               i_clock;
   logic               i_sys_rst;
   ccs_pkg::ccs_wr_t   i_wr;
   ccs_pkg::ccs_regs_t o_regs;
   ccs_pkg::ccs_src_t  cpu_src;
   logic               ring_en, main_osc_en, main_ext_en, sub_osc_en, sub_ext_en, hf_amp, clk_en;
   logic               main_rdy, sub_rdy, m;
   logic [7:0]         d, c;
   int                 error_cnt, checks_done, n;

   ccs_guard #(.HF_GATE_CYCLES(HF_CYC)) DUT
   (
      .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_wr(i_wr), .o_regs(o_regs), .o_ring_osc_en(ring_en),
      .o_main_osc_en(main_osc_en), .o_main_ext_en(main_ext_en), .o_sub_osc_en(sub_osc_en),
      .o_sub_ext_en(sub_ext_en), .o_hf_amp(hf_amp), .o_cpu_src(cpu_src), .o_cpu_clk_en(clk_en)
   );
   ccs_osc_model u_osc
   (
      .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_main_osc_en(main_osc_en), .i_main_ext_en(main_ext_en),
      .i_sub_osc_en(sub_osc_en), .i_sub_ext_en(sub_ext_en), .o_main_ready(main_rdy), .o_sub_ready(sub_rdy)
   );
   ////////////////////////////////////////////////////////////////////////////
   // 25 mhz clock
   initial
   begin
      i_clock = 1'b0;
      forever #20 i_clock = ~i_clock;
   end
   // compare and count
   task automatic chk(input logic [39:0] got, input logic [39:0] exp, input string what);
      checks_done++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk
   // one-cycle strobe; returns once the image shows the write
   task automatic wr(input int sel, input logic [7:0] v);
      @(posedge i_clock);
      #1;
      i_wr.wdata = v;
      {i_wr.cms_we, i_wr.moc_we, i_wr.mcm_we, i_wr.pcc_we, i_wr.rcm_we} = 5'b10000 >> sel;
      @(posedge i_clock);
      #1;
      i_wr = '0;
      @(posedge i_clock);
      #1;
   endtask : wr
   // bounded wait: 0 main ready, 1 sub ready, 2+ source settled with clock on
   task automatic wait_for(input int k);
      logic ok;
      for (int i = 0; i < 400; i++)
      begin
         ok = (k == 0) ? main_rdy : (k == 1) ? sub_rdy : (cpu_src === ccs_pkg::ccs_src_t'(k - 2)) && clk_en;
         if (ok === 1'b1)
            return;
         @(posedge i_clock);
         #1;
      end
      error_cnt++;
      $display("wrong value at %0t: wait %0d timed out", $time, k);
      test_done();
   endtask : wait_for
   // enables expected from the images: main osc, main ext, sub osc, sub ext
   function automatic logic [3:0] exp_en(input logic [7:0] cms, input logic stop);
      return {!stop && cms[6] && !cms[7], !stop && cms[6] && cms[7], cms[4] && !cms[5], cms[4] && cms[5]};
   endfunction : exp_en
   // verdict
   task automatic test_done();
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : test_done
   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial
   begin
      i_sys_rst = 1'b1;
      i_wr = '0;
      error_cnt = 0;
      checks_done = 0;
      void'($urandom(32'h5ebc));
      repeat (2) @(posedge i_clock);
      #1;
      i_sys_rst = 1'b0;
      @(posedge i_clock);
      #1;
      chk(o_regs, {ccs_pkg::CMS_RESET, ccs_pkg::MOC_RESET, 24'h0}, "reset images");
      chk({clk_en, ring_en, cpu_src}, {2'b11, ccs_pkg::CCS_SRC_RING}, "reset state");
      wr(RING_OSC_MODE_REG, 8'h01);
      chk({o_regs.ring_osc_mode_reg, ring_en}, 9'h001, "ring stop on ring");
      $display("test reset done");
      wr(MAIN_OSC_CONTROL_REG, 8'h00);
      wr(CMS, 8'h41);
      for (n = 0; n < 4 && clk_en === 1'b1; n++)
      begin
         @(posedge i_clock);
         #1;
      end
      n = 0;
      while (clk_en !== 1'b1 && n < 400)
      begin
         n++;
         @(posedge i_clock);
         #1;
      end
      chk(n >= HF_CYC && n < 400, 1, "hf hold");
      chk({main_osc_en, main_ext_en, hf_amp}, 3'b101, "crystal enable");
      wait_for(0);
      wr(MAIN_CLOCK_MODE_REG, 8'h05);
      wait_for(3);
      repeat (3) @(posedge i_clock);
      #1;
      chk(o_regs.main_clock_mode_reg, 8'h07, "on main");
      wr(RING_OSC_MODE_REG, 8'h01);
      chk({o_regs.ring_osc_mode_reg[0], ring_en}, 2'b10, "ring stop on main");
      wr(MAIN_OSC_CONTROL_REG, 8'h80);
      chk({o_regs.main_osc_control_reg, main_osc_en}, 9'h001, "main stop on main");
      $display("test main done");
      wr(CMS, 8'h71);
      chk(sub_ext_en, 1, "ext sub enable");
      wait_for(1);
      wr(PROCESSOR_CLOCK_CONTROL_REG, 8'h10);
      wait_for(4);
      chk({o_regs.processor_clock_control_reg, o_regs.main_clock_mode_reg, ring_en}, 17'h0200e, "on sub");
      wr(RING_OSC_MODE_REG, 8'h00);
      wr(MAIN_OSC_CONTROL_REG, 8'h80);
      chk({main_osc_en, main_ext_en}, 2'b00, "main stop on sub");
      wr(CMS, 8'h61);
      chk({o_regs.cms, sub_ext_en}, 9'he3, "sub stop on sub");
      wr(MAIN_CLOCK_MODE_REG, 8'h04);
      chk(o_regs.main_clock_mode_reg, 8'h04, "ring as main");
      wr(PROCESSOR_CLOCK_CONTROL_REG, 8'h00);
      wait_for(2);
      wr(CMS, 8'h61);
      wr(MAIN_CLOCK_MODE_REG, 8'h00);
      chk({o_regs.cms, o_regs.main_clock_mode_reg, sub_ext_en}, 17'h0c208, "sub stop after");
      $display("test sub done");
      m = 1'b1;
      c = 8'h61;
      for (int i = 0; i < 24; i++)
      begin
         d = $urandom;
         if (d[0])
         begin
            c = {d[7:4], 4'h1};
            wr(CMS, d);
         end
         else
         begin
            m = d[7];
            wr(MAIN_OSC_CONTROL_REG, d);
         end
         chk({o_regs.cms, o_regs.main_osc_control_reg, main_osc_en, main_ext_en, sub_osc_en, sub_ext_en},
             {c, m, 7'h0, exp_en(c, m)}, "random decode");
      end
      wr(PROCESSOR_CLOCK_CONTROL_REG, 8'h40);
      chk({o_regs.processor_clock_control_reg, sub_osc_en, sub_ext_en}, 10'h102, "sub amp start");
      $display("test random done");
      test_done();
   end
endmodule : cpu_clock_switch_guard_test

bind ccs_guard ccs_guard_props #(.HF_GATE_CYCLES(HF_GATE_CYCLES)) u_props
(
   .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_wr(i_wr), .o_regs(o_regs), .o_ring_osc_en(o_ring_osc_en),
   .o_main_osc_en(o_main_osc_en), .o_main_ext_en(o_main_ext_en), .o_sub_osc_en(o_sub_osc_en),
   .o_sub_ext_en(o_sub_ext_en), .o_hf_amp(o_hf_amp), .o_cpu_src(o_cpu_src), .o_cpu_clk_en(o_cpu_clk_en)
);
